// ===== common/atc_consts.svh
/*
 * Constants for the converter trigger and transfer control block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a byte-addressed local I/O port with 16-bit data.
 */
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses on the local I/O port)
// ****************************************************************
`define ATC_OFF_PACER_LO 8'h04
`define ATC_OFF_PACER_HI 8'h08
`define ATC_OFF_DAC_ONE 8'h10
`define ATC_OFF_DAC_TWO 8'h12
`define ATC_OFF_RESULT 8'h14
`define ATC_OFF_CTRL 8'h18
`define ATC_OFF_SWTRIG 8'h20

// ****************************************************************
// Converter control fields
// ****************************************************************
`define ATC_BIT_BMEN 0
`define ATC_BIT_INTEN 1
`define ATC_BIT_PACER 2
`define ATC_BIT_EXT 3
`define ATC_BIT_SCAN 4
`define ATC_MUX_LSB 5
`define ATC_MUX_MSB 8
`define ATC_GAIN_LSB 9
`define ATC_GAIN_MSB 12

// Status read at the control offset
`define ATC_BIT_DONE 0
`define ATC_BIT_OVR 1

// ****************************************************************
// Reset values
// ****************************************************************
`define ATC_CTRL_RST 16'h0000
`define ATC_DIV_RST 16'h0002
`define ATC_DAC_RST 12'h000
`define ATC_RESULT_RST 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ATC_CLK_PERIOD_NS 4
`define ATC_CONV_TIME_NS 8000
// Longest time, so the division rounds down
`define ATC_CONV_CYCLES (`ATC_CONV_TIME_NS / `ATC_CLK_PERIOD_NS)

// ****************************************************************
// Buffer
// ****************************************************************
`define ATC_FIFO_DEPTH 16
`define ATC_FIFO_WIDTH 16

`endif

// ===== common/atc_pkg.sv
/*
 * Types for the converter trigger and transfer control block.
 * Assumes atc_consts.svh supplies all numeric constants.
 */
package atc_pkg;

   // ****************************************************************
   // Conversion sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [1:0]
   {
      ATC_ST_IDLE = 2'b01,
      ATC_ST_CONV = 2'b10
   } atc_state_t;

endpackage : atc_pkg

// ===== core/atc_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, storage in flops.
 * Assumes one clock; width and depth are parameters, depth a power of 2.
 */
`timescale 1ns/1ps
module atc_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != (AW+1)'(D));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // ****************************************************************
   // Storage entries
   // ****************************************************************
   for (genvar i = 0; i < D; i++)
   begin : g_entry
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
            mem_q[i] <= '0;
         else if (push && (wr_q == AW'(i)))
            mem_q[i] <= in_data_i;
      end
   end

endmodule : atc_fifo

// ===== core/atc_ctrl.sv
/*
 * Converter trigger selection, conversion sequencing, result delivery
 * (polling, interrupt, bus-master FIFO) and two output code registers.
 * Assumes a byte-addressed 16-bit local I/O port on clk_i, a converter
 * whose sample is stable at the end of the conversion time, and a
 * bus-master engine that drains the result stream.
 */
// Notes on behaviour
// - Done flag low during conversion, set when result readable.
// - External source selected: software and pacer triggers are ignored.
// - Source chosen by external select and pacer-or-software bits.
// - In software mode, a write to software trigger register while idle starts one conversion.
// - Pacer: two cascaded counters give periodic triggers.
// - External mode: each rising edge of trigger input while idle starts conversion.
// - External trigger works with bus-master, interrupt or polling.
// - Pacer works with bus-master or interrupt delivery.
// - Delivery chosen by interrupt and bus-master enable bits.
// - Reading result low byte clears done flag.
// - Conversion finishes within 8 us; host may wait instead.
// - Interrupt enabled: request raised when result becomes ready.
// - Bus-master enabled: results queue in FIFO and leave unaided.
// - Bus-master results go to host memory without processor work.
// - Two outputs, each driven from its last written code.
// - Output code is unsigned 12-bit, scale reference times code/4096.
// - Sixteen single-ended or eight differential inputs by board strap.
// - Overrun flag set when bus-master delivery loses data.
// - Auto-scan walks channels downward from programmed one to 0.
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_ctrl
   import atc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Local I/O port
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [15:0] io_wdata_i,
   output logic [15:0] io_rdata_o,
   // Board pins
   input wire logic external_trigger_input_i,
   input wire logic diff_mode_i,
   // Converter
   output logic adc_start_o,
   output logic [3:0] adc_channel_o,
   output logic [3:0] adc_gain_o,
   input wire logic [11:0] adc_sample_i,
   // Host interrupt
   output logic irq_o,
   // Bus-master stream
   output logic dma_valid_o,
   output logic [15:0] dma_data_o,
   input wire logic dma_ready_i,
   // Output codes
   output logic [11:0] analog_output_one_o,
   output logic [11:0] analog_output_two_o
);

   localparam logic [10:0] CONV_LAST = 11'(`ATC_CONV_CYCLES - 1);

   // ****************************************************************
   // Access decode
   // ****************************************************************
   logic wr_ctrl, wr_swtrig, wr_div1, wr_div2, wr_dac1, wr_dac2, rd_res;

   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_swtrig = 1'b0;
      wr_div1 = 1'b0;
      wr_div2 = 1'b0;
      wr_dac1 = 1'b0;
      wr_dac2 = 1'b0;
      if (io_wr_i && io_addr_i == `ATC_OFF_CTRL)
         wr_ctrl = 1'b1;
      else if (io_wr_i && io_addr_i == `ATC_OFF_SWTRIG)
         wr_swtrig = 1'b1;
      else if (io_wr_i && io_addr_i == `ATC_OFF_PACER_LO)
         wr_div1 = 1'b1;
      else if (io_wr_i && io_addr_i == `ATC_OFF_PACER_HI)
         wr_div2 = 1'b1;
      else if (io_wr_i && io_addr_i == `ATC_OFF_DAC_ONE)
         wr_dac1 = 1'b1;
      else if (io_wr_i && io_addr_i == `ATC_OFF_DAC_TWO)
         wr_dac2 = 1'b1;
      rd_res = io_rd_i && (io_addr_i == `ATC_OFF_RESULT);
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Level only moves once the second and third stages agree
   logic [2:0] ext_s_q, dif_s_q;
   logic ext_lvl_q, ext_lvl_d, dif_lvl_q, dif_lvl_d, ext_rise;

   always_comb
   begin
      ext_lvl_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_lvl_q;
      dif_lvl_d = (dif_s_q[1] == dif_s_q[2]) ? dif_s_q[2] : dif_lvl_q;
      ext_rise = ext_s_q[1] & ext_s_q[2] & ~ext_lvl_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ext_s_q <= 3'h0;
         dif_s_q <= 3'h0;
         ext_lvl_q <= 1'b0;
         dif_lvl_q <= 1'b0;
      end
      else
      begin
         ext_s_q <= {ext_s_q[1:0], external_trigger_input_i};
         dif_s_q <= {dif_s_q[1:0], diff_mode_i};
         ext_lvl_q <= ext_lvl_d;
         dif_lvl_q <= dif_lvl_d;
      end
   end

   // ****************************************************************
   // Control and output code registers
   // ****************************************************************
   logic [15:0] ctrl_q, ctrl_d, div1_q, div1_d, div2_q, div2_d;
   logic [11:0] dac1_q, dac1_d, dac2_q, dac2_d;
   logic sel_ext, sel_pacer, en_int, en_bm, en_scan;

   always_comb
   begin
      ctrl_d = wr_ctrl ? io_wdata_i : ctrl_q;
      div1_d = wr_div1 ? io_wdata_i : div1_q;
      div2_d = wr_div2 ? io_wdata_i : div2_q;
      dac1_d = wr_dac1 ? io_wdata_i[11:0] : dac1_q;
      dac2_d = wr_dac2 ? io_wdata_i[11:0] : dac2_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_q <= `ATC_CTRL_RST;
         div1_q <= `ATC_DIV_RST;
         div2_q <= `ATC_DIV_RST;
         dac1_q <= `ATC_DAC_RST;
         dac2_q <= `ATC_DAC_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         div1_q <= div1_d;
         div2_q <= div2_d;
         dac1_q <= dac1_d;
         dac2_q <= dac2_d;
      end
   end

   assign sel_ext = ctrl_q[`ATC_BIT_EXT];
   assign sel_pacer = ctrl_q[`ATC_BIT_PACER];
   assign en_int = ctrl_q[`ATC_BIT_INTEN];
   assign en_bm = ctrl_q[`ATC_BIT_BMEN];
   assign en_scan = ctrl_q[`ATC_BIT_SCAN];
   assign analog_output_one_o = dac1_q;
   assign analog_output_two_o = dac2_q;

   // ****************************************************************
   // Pacer: two cascaded down counters
   // ****************************************************************
   // A divisor of zero wraps and acts as 65536
   logic [15:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
   logic pace, pacer_run;

   always_comb
   begin
      pacer_run = ~sel_ext & sel_pacer;
      cnt1_d = cnt1_q;
      cnt2_d = cnt2_q;
      pace = 1'b0;
      if (!pacer_run || wr_div1 || wr_div2)
      begin
         cnt1_d = div1_q;
         cnt2_d = div2_q;
      end
      else if (cnt1_q == 16'h0001)
      begin
         cnt1_d = div1_q;
         if (cnt2_q == 16'h0001)
         begin
            cnt2_d = div2_q;
            pace = 1'b1;
         end
         else
            cnt2_d = cnt2_q - 16'h0001;
      end
      else
         cnt1_d = cnt1_q - 16'h0001;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt1_q <= `ATC_DIV_RST;
         cnt2_q <= `ATC_DIV_RST;
      end
      else
      begin
         cnt1_q <= cnt1_d;
         cnt2_q <= cnt2_d;
      end
   end

   // ****************************************************************
   // Conversion sequencer and result delivery
   // ****************************************************************
   atc_state_t state_q, state_d;
   logic [10:0] conv_q, conv_d;
   logic [3:0] chan_q, chan_d, mux;
   logic [15:0] res_q, res_d;
   logic done_q, done_d, ovr_q, ovr_d, irq_q, irq_d, start_q, start_d;
   logic trig, conv_end, push, fifo_rdy;

   always_comb
   begin
      // Take the channel being written, so a reload sees the new field
      mux = ctrl_d[`ATC_MUX_MSB:`ATC_MUX_LSB];
      if (dif_lvl_q)
         mux[3] = 1'b0;
      // External selection masks both internal sources
      if (sel_ext)
         trig = ext_rise;
      else if (sel_pacer)
         trig = pace;
      else
         trig = wr_swtrig;
      state_d = state_q;
      conv_d = conv_q;
      chan_d = chan_q;
      res_d = res_q;
      start_d = 1'b0;
      conv_end = 1'b0;
      case (state_q)
         ATC_ST_IDLE:
         begin
            if (wr_ctrl)
               chan_d = mux;
            else if (trig)
            begin
               start_d = 1'b1;
               conv_d = CONV_LAST;
               state_d = ATC_ST_CONV;
            end
         end
         ATC_ST_CONV:
         begin
            // Triggers are not looked at here
            if (conv_q == 11'h000)
            begin
               conv_end = 1'b1;
               res_d = {chan_q, adc_sample_i};
               state_d = ATC_ST_IDLE;
               if (!en_scan)
                  chan_d = mux;
               else if (chan_q == 4'h0)
                  chan_d = mux;
               else
                  chan_d = chan_q - 4'h1;
            end
            else
               conv_d = conv_q - 11'h001;
         end
         default:
            state_d = ATC_ST_IDLE;
      endcase
      push = conv_end & en_bm;
      // Hardware set wins over a same-cycle clear
      done_d = done_q;
      if (start_d)
         done_d = 1'b0;
      else if (conv_end)
         done_d = 1'b1;
      else if (rd_res)
         done_d = 1'b0;
      irq_d = irq_q;
      if (conv_end && en_int)
         irq_d = 1'b1;
      else if (rd_res)
         irq_d = 1'b0;
      ovr_d = ovr_q;
      if (push && !fifo_rdy)
         ovr_d = 1'b1;
      else if (wr_ctrl)
         ovr_d = 1'b0;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_q <= ATC_ST_IDLE;
         conv_q <= 11'h000;
         chan_q <= 4'h0;
         res_q <= `ATC_RESULT_RST;
         start_q <= 1'b0;
         done_q <= 1'b0;
         irq_q <= 1'b0;
         ovr_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         conv_q <= conv_d;
         chan_q <= chan_d;
         res_q <= res_d;
         start_q <= start_d;
         done_q <= done_d;
         irq_q <= irq_d;
         ovr_q <= ovr_d;
      end
   end

   assign adc_start_o = start_q;
   assign adc_channel_o = chan_q;
   assign adc_gain_o = ctrl_q[`ATC_GAIN_MSB:`ATC_GAIN_LSB];
   assign irq_o = irq_q;

   // ****************************************************************
   // Bus-master stream: FIFO then an output flop stage
   // ****************************************************************
   // A full FIFO drops the new result and flags overrun, since the
   // converter cannot be paused mid-stream
   logic fifo_vld, fifo_pop, dvld_q, dvld_d;
   logic [15:0] fifo_dat, ddat_q, ddat_d;

   atc_fifo #(
      .W(`ATC_FIFO_WIDTH),
      .D(`ATC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push),
      .in_ready_o(fifo_rdy),
      .in_data_i(res_d),
      .out_valid_o(fifo_vld),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_dat)
   );

   always_comb
   begin
      fifo_pop = ~dvld_q | dma_ready_i;
      dvld_d = fifo_pop ? fifo_vld : dvld_q;
      ddat_d = (fifo_pop && fifo_vld) ? fifo_dat : ddat_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dvld_q <= 1'b0;
         ddat_q <= 16'h0000;
      end
      else
      begin
         dvld_q <= dvld_d;
         ddat_q <= ddat_d;
      end
   end

   assign dma_valid_o = dvld_q;
   assign dma_data_o = ddat_q;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [15:0] rdat_q, rdat_d;

   always_comb
   begin
      rdat_d = 16'h0000;
      if (io_rd_i && io_addr_i == `ATC_OFF_CTRL)
      begin
         rdat_d[`ATC_BIT_DONE] = done_q;
         rdat_d[`ATC_BIT_OVR] = ovr_q;
      end
      else if (rd_res)
         rdat_d = res_q;
      else if (io_rd_i && io_addr_i == `ATC_OFF_PACER_LO)
         rdat_d = div1_q;
      else if (io_rd_i && io_addr_i == `ATC_OFF_PACER_HI)
         rdat_d = div2_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rdat_q <= 16'h0000;
      else
         rdat_q <= rdat_d;
   end

   assign io_rdata_o = rdat_q;

endmodule : atc_ctrl

// ===== dv/atc_ctrl_checker.sv
/*
 * Port checker for atc_ctrl: trigger spacing and masking, interrupt
 * timing, stream hold and code registers. Bound to every atc_ctrl.
 */
`timescale 1ns/1ps
module atc_ctrl_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Local I/O port
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [15:0] io_wdata_i,
   input wire logic [15:0] io_rdata_o,
   // Pin and converter
   input wire logic external_trigger_input_i,
   input wire logic adc_start_o,
   // Delivery
   input wire logic irq_o,
   input wire logic dma_valid_o,
   input wire logic [15:0] dma_data_o,
   input wire logic dma_ready_i,
   // Output codes
   input wire logic [11:0] analog_output_one_o,
   input wire logic [11:0] analog_output_two_o
);
   // ************
   // Helper state
   // ************
   // Cycles since the last start, parked at 0xfff once long idle
   logic [11:0] since_q, since_d;
   logic [3:0] mode_q, mode_d;
   logic [5:0] pin_q, pin_d;

   always_comb
   begin
      since_d = since_q;
      if (adc_start_o)
         since_d = 12'h001;
      else if (since_q != 12'hfff)
         since_d = since_q + 12'h001;
      mode_d = mode_q;
      if (io_wr_i && io_addr_i == 8'h18)
         mode_d = io_wdata_i[3:0];
      pin_d = {pin_q[4:0], external_trigger_input_i};
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         since_q <= 12'hfff;
         mode_q <= 4'h0;
         pin_q <= 6'h3f;
      end
      else
      begin
         since_q <= since_d;
         mode_q <= mode_d;
         pin_q <= pin_d;
      end
   end

   // ************
   // Properties
   // ************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // Pin rose one sample ago while idle in external mode
   sequence s_ext_rise;
      mode_q[3] && since_q > 12'd2002 && pin_q[1:0] == 2'b01;
   endsequence
   // Synchroniser plus start register, with some slack
   sequence s_start_soon;
      ##[1:6] adc_start_o;
   endsequence

   AST_START_SPACING: assert property (adc_start_o |-> since_q > 12'd2000)
      else $error("conversion restarted too early");
   AST_IRQ_AT_END: assert property ($rose(irq_o) |-> since_q == 12'd2000)
      else $error("interrupt not at conversion end");
   AST_IRQ_RELEASE: assert property (io_rd_i && io_addr_i == 8'h14 &&
      since_q != 12'd1999 |=> !irq_o) else $error("interrupt not released");
   AST_DONE_LOW: assert property (io_rd_i && io_addr_i == 8'h18 &&
      since_q < 12'd1999 |=> io_rdata_o[0] == 1'b0)
      else $error("done flag high while converting");
   AST_SW_START: assert property (mode_q[3:2] == 2'b00 &&
      since_q > 12'd2002 && io_wr_i && io_addr_i == 8'h20 |=> adc_start_o)
      else $error("software trigger did not start");
   AST_SW_QUIET: assert property (mode_q[3:2] == 2'b00 &&
      $past(mode_q[3:2], 2) == 2'b00 && !(io_wr_i && io_addr_i == 8'h20)
      |=> !adc_start_o) else $error("start without software write");
   AST_EXT_MASKS: assert property (mode_q[3] && $past(mode_q[3], 2) &&
      pin_q == 6'h00 |=> !adc_start_o)
      else $error("internal trigger in external mode");
   AST_EXT_EDGE: assert property (s_ext_rise |-> s_start_soon)
      else $error("external edge did not start");
   AST_STREAM_HOLD: assert property (dma_valid_o && !dma_ready_i |=>
      dma_valid_o && $stable(dma_data_o)) else $error("stream word dropped");
   AST_CODE_ONE: assert property (io_wr_i && io_addr_i == 8'h10 |=>
      analog_output_one_o == $past(io_wdata_i[11:0]))
      else $error("output code one wrong");
   AST_CODE_TWO: assert property (io_wr_i && io_addr_i == 8'h12 |=>
      analog_output_two_o == $past(io_wdata_i[11:0]))
      else $error("output code two wrong");
endmodule : atc_ctrl_checker

bind atc_ctrl atc_ctrl_checker i_chk (.clk_i, .arst_n_i, .io_addr_i,
   .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .external_trigger_input_i,
   .adc_start_o, .irq_o, .dma_valid_o, .dma_data_o, .dma_ready_i,
   .analog_output_one_o, .analog_output_two_o);

// ===== dv/atc_bm_sink.sv
/*
 * Result stream sink standing in for the host bus-master engine.
 * Assumes the bench holds stall_i high to let the buffer fill.
 */
`timescale 1ns/1ps
module atc_bm_sink (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Bench control
   input wire logic stall_i,
   // Result stream
   input wire logic dma_valid_i,
   input wire logic [15:0] dma_data_i,
   output logic dma_ready_o
);
   logic [15:0] words[$];
   logic slow_q;

   // Ready every other cycle: a slow taker exercises the output stage
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         slow_q <= 1'b0;
         dma_ready_o <= 1'b0;
      end
      else
      begin
         slow_q <= ~slow_q;
         dma_ready_o <= !stall_i && slow_q;
         if (dma_valid_i && dma_ready_o)
            words.push_back(dma_data_i);
      end
   end
endmodule : atc_bm_sink

// ===== dv/tb_top.sv
/*
 * Testbench for atc_ctrl: register tasks on the local I/O port, then
 * trigger modes, delivery modes, pacer, scan and buffer overrun.
 */
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] io_addr_i = 8'h00;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [15:0] io_wdata_i = 16'h0000;
   logic ext_pin = 1'b0;
   logic stall = 1'b0;
   logic diff = 1'b0;
   logic [15:0] io_rdata_o, dma_data;
   logic adc_start_o, irq_o, dma_valid, dma_ready;
   logic [11:0] code_one, code_two;
   logic [3:0] chan, gain;
   logic [15:0] modes[3] = '{16'h0008, 16'h000a, 16'h0009};
   logic [15:0] d;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   int t0;

   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   atc_ctrl i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .external_trigger_input_i(ext_pin), .diff_mode_i(diff),
      .adc_start_o(adc_start_o), .adc_channel_o(chan), .adc_gain_o(gain),
      .adc_sample_i(12'habc), .irq_o(irq_o), .dma_valid_o(dma_valid),
      .dma_data_o(dma_data), .dma_ready_i(dma_ready),
      .analog_output_one_o(code_one), .analog_output_two_o(code_two));

   atc_bm_sink i_sink (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .stall_i(stall), .dma_valid_i(dma_valid), .dma_data_i(dma_data),
      .dma_ready_o(dma_ready));

   // ************
   // Tasks
   // ************
   task automatic complete_run;
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_i);
      io_addr_i <= a;
      io_wdata_i <= v;
      io_wr_i <= 1'b1;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
      #1;
   endtask : wr

   // Read data stands for the one cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_i);
      io_addr_i <= a;
      io_rd_i <= 1'b1;
      @(posedge clk_i);
      io_rd_i <= 1'b0;
      #1;
      v = io_rdata_o;
   endtask : rd

   task automatic wait_start(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         #1;
         if (adc_start_o === 1'b1)
            return;
      end
      failures++;
      $display("Error start expected 1 seen 0");
      complete_run();
   endtask : wait_start

   // ************
   // Sequence
   // ************
   initial
   begin
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rd(8'h18, d);
      chk("status", 16'h0000, d);
      rd(8'h3c, d);
      chk("unmapped", 16'h0000, d);
      wr(8'h10, 16'h0fff);
      wr(8'h12, 16'h0001);
      chk("code one", 16'h0fff, {4'h0, code_one});
      chk("code two", 16'h0001, {4'h0, code_two});
      // Software trigger with polling on channel 5
      wr(8'h18, 16'h00a0);
      chk("channel", 16'h0005, {12'h0, chan});
      wr(8'h20, 16'h5a5a);
      t0 = cyc;
      rd(8'h18, d);
      chk("done busy", 16'h0000, d);
      wr(8'h20, 16'h0000);
      for (int i = 0; i < 1500 && d[0] !== 1'b1; i++)
         rd(8'h18, d);
      chk("done", 16'h0001, d);
      if (d[0] !== 1'b1)
         complete_run();
      chk("in time", 16'h0001, {15'h0, cyc - t0 <= 2006});
      rd(8'h14, d);
      chk("result", 16'h5abc, d);
      rd(8'h18, d);
      chk("done cleared", 16'h0000, d);
      // External trigger with polling, interrupt and bus-master
      foreach (modes[m])
      begin
         wr(8'h18, modes[m]);
         wr(8'h20, 16'h0000);
         repeat (2100) @(posedge clk_i);
         rd(8'h18, d);
         chk("ext masks sw", 16'h0000, d);
         @(posedge clk_i);
         ext_pin <= 1'b1;
         wait_start(12);
         @(posedge clk_i);
         ext_pin <= 1'b0;
         repeat (2010) @(posedge clk_i);
         #1;
         chk("irq", {15'h0, modes[m][1]}, {15'h0, irq_o});
         rd(8'h18, d);
         chk("ext done", 16'h0001, d);
         rd(8'h14, d);
         chk("ext result", 16'h0abc, d);
         chk("irq cleared", 16'h0000, {15'h0, irq_o});
      end
      chk("bm count", 16'h0001, 16'(i_sink.words.size()));
      chk("bm word", 16'h0abc, i_sink.words[0]);
      // Pacer with bus-master and scan from channel 2, taker stalled
      @(posedge clk_i);
      stall <= 1'b1;
      wr(8'h04, 16'h0002);
      wr(8'h08, 16'h03e9);
      rd(8'h08, d);
      chk("divisor", 16'h03e9, d);
      wr(8'h18, 16'h0055);
      wait_start(2100);
      t0 = cyc;
      wait_start(2100);
      chk("pacer period", 16'd2002, 16'(cyc - t0));
      repeat (17) wait_start(2100);
      // Back to software mode so only the conversion in progress pushes once more
      wr(8'h18, 16'h0051);
      repeat (2010) @(posedge clk_i);
      rd(8'h18, d);
      chk("overrun", 16'h0003, d);
      wr(8'h18, 16'h0051);
      rd(8'h18, d);
      chk("overrun clear", 16'h0001, d);
      @(posedge clk_i);
      stall <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk("bm total", 16'd18, 16'(i_sink.words.size()));
      for (int k = 0; k < 17; k++)
         chk("scan word", {4'(2 - k % 3), 12'habc}, i_sink.words[k + 1]);
      // Differential strap drops the top channel bit
      @(posedge clk_i);
      diff <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr(8'h18, 16'h1fe0);
      chk("diff channel", 16'h0007, {12'h0, chan});
      chk("gain", 16'h000f, {12'h0, gain});
      complete_run();
   end
endmodule : tb_top
